// File: design/monitor_control_pkg.sv
package monitor_control_pkg;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned DAC_N = 8;
  localparam int unsigned MF_N = 4;
  localparam int unsigned EV_N = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h04;
  localparam logic [7:0] OFS_GPIO_IN = 8'h08;
  localparam logic [7:0] OFS_CLAMP = 8'h0c;
  localparam logic [7:0] OFS_TX = 8'h10;
  localparam logic [7:0] OFS_RX = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // Multifunction pin index
  localparam int unsigned PIN_ALERT = 0;
  localparam int unsigned PIN_PD0 = 1;
  localparam int unsigned PIN_PD1 = 2;
  localparam int unsigned PIN_LOAD = 3;

  // Interrupt event bits
  localparam int unsigned EV_FRAME = 0;
  localparam int unsigned EV_RANGE = 1;
  localparam int unsigned EV_LOAD = 2;

  // Synchroniser bit positions
  localparam int unsigned SY_RST = 7;
  localparam int unsigned SY_SCLK = 6;
  localparam int unsigned SY_CS = 5;
  localparam int unsigned SY_DIN = 4;
  // Reset, chip select and mf pins idle high, link clock and data low, so no false edge follows reset
  localparam logic [7:0] SYNC_RST = 8'haf;

  // Control: pol bit 1 means active high, gpio_sel bit 1 means GPIO role
  typedef struct packed {
    logic [3:0] pol;
    logic [3:0] gpio_sel;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 8'h00;

  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] out;
  } gpio_t;
  localparam gpio_t GPIO_RST = 8'h00;

  typedef struct packed {
    logic [7:0] mask1;
    logic [7:0] mask0;
  } clamp_t;
  localparam clamp_t CLAMP_RST = 16'h0000;

  typedef struct packed {
    logic en;
    logic [15:0] data;
  } tx_t;
  localparam tx_t TX_RST = 17'h00000;

  typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;
endpackage : monitor_control_pkg

// File: design/monitor_control_pin_interface.sv
`timescale 1ns/100ps
module monitor_control_pin_interface
  import monitor_control_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic hw_reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic [MF_N-1:0] mf_pin_i,
  output logic [MF_N-1:0] mf_pin_o,
  output logic [MF_N-1:0] mf_pin_oe_o,
  input wire logic out_of_range_i,
  output logic [DAC_N-1:0] dac_clamp_o,
  output logic dac_load_o
);

  // Synchronisers
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic rst_int;
  logic sclk_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_s;
  logic din_s;
  logic [MF_N-1:0] pin_s;
  // Registers
  ctrl_t ctrl_r, ctrl_nxt;
  gpio_t gpio_r, gpio_nxt;
  clamp_t clamp_r, clamp_nxt;
  tx_t tx_r, tx_nxt;
  logic [EV_N-1:0] stat_r, stat_nxt;
  logic [EV_N-1:0] mask_r, mask_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic irq_r, irq_nxt;
  // Link
  link_state_t state_r, state_nxt;
  logic [FRAME_W-1:0] rx_shift_r, rx_shift_nxt;
  logic [FRAME_W-1:0] rx_data_r, rx_data_nxt;
  logic [FRAME_W-1:0] tx_shift_r, tx_shift_nxt;
  logic dout_oe_r, dout_oe_nxt;
  logic frame_ev;
  // Pins
  logic [MF_N-1:0] pin_o_r, pin_o_nxt;
  logic [MF_N-1:0] pin_oe_r, pin_oe_nxt;
  logic [DAC_N-1:0] clamp_o_r, clamp_o_nxt;
  logic load_r, load_nxt;
  logic range_q_r;
  logic pd0_act;
  logic pd1_act;
  logic [EV_N-1:0] events;
  // Bus helpers
  logic hit;
  logic wr;
  logic [31:0] bm;
  logic [31:0] rdat;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {hw_reset_n_i, sclk_i, cs_n_i, din_i, mf_pin_i};
      sync2_r <= sync1_r;
    end
  end

  assign rst_int = !rst_n_i || !sync2_r[SY_RST];
  assign cs_s = sync2_r[SY_CS];
  assign din_s = sync2_r[SY_DIN];
  assign pin_s = sync2_r[MF_N-1:0];
  assign sclk_rise = sync2_r[SY_SCLK] && !sclk_d_r;
  assign sclk_fall = !sync2_r[SY_SCLK] && sclk_d_r;

  // Serial link
  always_comb begin
    state_nxt = state_r;
    rx_shift_nxt = rx_shift_r;
    rx_data_nxt = rx_data_r;
    tx_shift_nxt = tx_shift_r;
    dout_oe_nxt = dout_oe_r;
    frame_ev = 1'b0;
    case (state_r)
      LINK_IDLE: begin
        if (!cs_s) begin
          state_nxt = LINK_FRAME;
          rx_shift_nxt = '0;
          tx_shift_nxt = tx_r.data;
          dout_oe_nxt = tx_r.en;
        end
      end
      LINK_FRAME: begin
        if (cs_s) begin
          state_nxt = LINK_IDLE;
          rx_data_nxt = rx_shift_r;
          frame_ev = 1'b1;
          dout_oe_nxt = 1'b0;
        end else begin
          if (sclk_rise) begin
            rx_shift_nxt = {rx_shift_r[FRAME_W-2:0], din_s};
          end
          if (sclk_fall) begin
            tx_shift_nxt = {tx_shift_r[FRAME_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        state_nxt = LINK_IDLE;
        dout_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_int) begin
      state_r <= LINK_IDLE;
      rx_shift_r <= '0;
      rx_data_r <= '0;
      tx_shift_r <= '0;
      dout_oe_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_data_r <= rx_data_nxt;
      tx_shift_r <= tx_shift_nxt;
      dout_oe_r <= dout_oe_nxt;
      sclk_d_r <= sync2_r[SY_SCLK];
    end
  end

  // Multifunction pins
  assign pd0_act = (pin_s[PIN_PD0] == ctrl_r.pol[PIN_PD0]) && !ctrl_r.gpio_sel[PIN_PD0];
  assign pd1_act = (pin_s[PIN_PD1] == ctrl_r.pol[PIN_PD1]) && !ctrl_r.gpio_sel[PIN_PD1];

  genvar gi;
  generate
    for (gi = 0; gi < MF_N; gi++) begin : g_pin
      if (gi == PIN_ALERT) begin : g_od
        assign pin_o_nxt[gi] = 1'b0;
        assign pin_oe_nxt[gi] = ctrl_r.gpio_sel[gi] ? (gpio_r.oe[gi] && !gpio_r.out[gi])
                                                    : (out_of_range_i != ctrl_r.pol[gi]);
      end else begin : g_pp
        assign pin_o_nxt[gi] = ctrl_r.gpio_sel[gi] && gpio_r.out[gi];
        assign pin_oe_nxt[gi] = ctrl_r.gpio_sel[gi] && gpio_r.oe[gi];
      end
    end
  endgenerate

  always_comb begin
    clamp_o_nxt = (pd0_act ? clamp_r.mask0 : '0) | (pd1_act ? clamp_r.mask1 : '0);
    load_nxt = !ctrl_r.gpio_sel[PIN_LOAD] && (pin_s[PIN_LOAD] == ctrl_r.pol[PIN_LOAD]);
    events = '0;
    events[EV_FRAME] = frame_ev;
    events[EV_RANGE] = out_of_range_i && !range_q_r;
    events[EV_LOAD] = load_nxt && !load_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_int) begin
      pin_o_r <= '0;
      pin_oe_r <= '0;
      clamp_o_r <= '0;
      load_r <= 1'b0;
      range_q_r <= 1'b0;
    end else begin
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
      clamp_o_r <= clamp_o_nxt;
      load_r <= load_nxt;
      range_q_r <= out_of_range_i;
    end
  end

  // Wishbone slave, one registered ack per request, a cycle after the strobe
  assign hit = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = hit && wb_we_i;
  assign bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    case (wb_adr_i)
      OFS_CTRL: rdat = {24'h000000, ctrl_r};
      OFS_GPIO_OUT: rdat = {24'h000000, gpio_r};
      OFS_GPIO_IN: rdat = {28'h0000000, pin_s};
      OFS_CLAMP: rdat = {16'h0000, clamp_r};
      OFS_TX: rdat = {15'h0000, tx_r};
      OFS_RX: rdat = {16'h0000, rx_data_r};
      OFS_IRQ_STAT: rdat = {29'h00000000, stat_r};
      OFS_IRQ_MASK: rdat = {29'h00000000, mask_r};
      default: rdat = 32'h00000000;
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    gpio_nxt = gpio_r;
    clamp_nxt = clamp_r;
    tx_nxt = tx_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    ack_nxt = hit;
    dat_nxt = (hit && !wb_we_i) ? rdat : 32'h00000000;
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: ctrl_nxt = ctrl_t'((ctrl_r & ~bm[7:0]) | (wb_dat_i[7:0] & bm[7:0]));
        OFS_GPIO_OUT: gpio_nxt = gpio_t'((gpio_r & ~bm[7:0]) | (wb_dat_i[7:0] & bm[7:0]));
        OFS_CLAMP: clamp_nxt = clamp_t'((clamp_r & ~bm[15:0]) | (wb_dat_i[15:0] & bm[15:0]));
        OFS_TX: tx_nxt = tx_t'((tx_r & ~bm[16:0]) | (wb_dat_i[16:0] & bm[16:0]));
        OFS_IRQ_MASK: mask_nxt = (mask_r & ~bm[2:0]) | (wb_dat_i[2:0] & bm[2:0]);
        OFS_IRQ_STAT: stat_nxt = stat_r & ~(wb_dat_i[2:0] & bm[2:0]);
        default: ;
      endcase
    end
    // Set wins over clear
    stat_nxt = stat_nxt | events;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_int) begin
      ctrl_r <= CTRL_RST;
      gpio_r <= GPIO_RST;
      clamp_r <= CLAMP_RST;
      tx_r <= TX_RST;
      stat_r <= '0;
      mask_r <= '0;
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      gpio_r <= gpio_nxt;
      clamp_r <= clamp_nxt;
      tx_r <= tx_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign irq_o = irq_r;
  assign dout_o = tx_shift_r[FRAME_W-1];
  assign dout_oe_o = dout_oe_r;
  assign mf_pin_o = pin_o_r;
  assign mf_pin_oe_o = pin_oe_r;
  assign dac_clamp_o = clamp_o_r;
  assign dac_load_o = load_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_int);
  property p_alert_default;
    @(posedge sys_clk_i) disable iff (1'b0) rst_int |=> !ctrl_r.gpio_sel[PIN_ALERT] && !ctrl_r.gpio_sel[PIN_LOAD];
  endproperty
  a_alert_default: assert property (p_alert_default) else $error("Alternate role not set after reset");
  property p_alert_level;
    !ctrl_r.gpio_sel[PIN_ALERT] |=> mf_pin_oe_o[PIN_ALERT] == ($past(out_of_range_i) != $past(ctrl_r.pol[PIN_ALERT]));
  endproperty
  a_alert_level: assert property (p_alert_level) else $error("Alert level wrong");
  property p_open_drain;
    !mf_pin_o[PIN_ALERT];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Alert pin driven high");
  property p_pd_input;
    !ctrl_r.gpio_sel[PIN_PD0] && !ctrl_r.gpio_sel[PIN_PD1] |=> !mf_pin_oe_o[PIN_PD0] && !mf_pin_oe_o[PIN_PD1];
  endproperty
  a_pd_input: assert property (p_pd_input) else $error("Power-down pin driven");
  property p_clamp;
    pd0_act |=> (dac_clamp_o & $past(clamp_r.mask0)) == $past(clamp_r.mask0);
  endproperty
  a_clamp: assert property (p_clamp) else $error("Clamp subset missing");
  property p_hw_reset;
    @(posedge sys_clk_i) disable iff (1'b0) !sync2_r[SY_RST] |=> ctrl_r == CTRL_RST && !dout_oe_o && !irq_o;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("Pin reset ignored");
  property p_load;
    !ctrl_r.gpio_sel[PIN_LOAD] && (pin_s[PIN_LOAD] == ctrl_r.pol[PIN_LOAD]) |=> dac_load_o;
  endproperty
  a_load: assert property (p_load) else $error("Load not active");
  property p_rx_sample;
    state_r == LINK_FRAME && !cs_s && sclk_rise |=> rx_shift_r[0] == $past(din_s);
  endproperty
  a_rx_sample: assert property (p_rx_sample) else $error("Input bit not sampled");
  property p_tx_shift;
    state_r == LINK_FRAME && !cs_s && sclk_fall |=> tx_shift_r == {$past(tx_shift_r[FRAME_W-2:0]), 1'b0};
  endproperty
  a_tx_shift: assert property (p_tx_shift) else $error("Output not shifted");
  property p_dout_hiz;
    cs_s ##1 cs_s |=> !dout_oe_o;
  endproperty
  a_dout_hiz: assert property (p_dout_hiz) else $error("Output driven outside frame");
  c_frame: cover property (frame_ev && tx_r.en);
  c_alert: cover property (!ctrl_r.gpio_sel[PIN_ALERT] && $rose(out_of_range_i));
  c_clamp: cover property (pd0_act && pd1_act);
  c_irq: cover property ($rose(irq_o));
endmodule : monitor_control_pin_interface

// File: tb/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  input wire logic sys_clk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // Half period of the 200 ns link clock, in system cycles
  localparam int HALF = 4;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic oe_mid);
    logic line;
    line = 1'b0;
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    din_o <= tx[15];
    repeat (HALF) @(posedge sys_clk_i);
    for (int i = 0; i < 16; i++) begin
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge sys_clk_i);
      // Released line reads as the inverse of the last bit
      line = (dout_oe_o === 1'b1) ? dout_o : ~line;
      if (i == 0) oe_mid = dout_oe_o;
      rx[15 - i] = line;
      sclk_o <= 1'b0;
      din_o <= (i < 15) ? tx[14 - i] : ~din_o;
      repeat (HALF) @(posedge sys_clk_i);
    end
    cs_n_o <= 1'b1;
  endtask : xfer
endmodule : serial_host_model

// File: tb/tb_monitor_control_pin_interface.sv
`timescale 1ns/100ps
module tb_monitor_control_pin_interface;
  import monitor_control_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, dout_o, dout_oe_o, dac_load_o, sclk_i, cs_n_i, din_i;
  logic hw_reset_n_i = 1'b1;
  logic out_of_range_i = 1'b0;
  logic [3:1] pins_r = 3'h7;
  logic [MF_N-1:0] mf_pin_o, mf_pin_oe_o;
  logic [DAC_N-1:0] dac_clamp_o;
  // Open-drain pin with pull-up
  wire [MF_N-1:0] mf_pin_i = {pins_r, ~(mf_pin_oe_o[0] === 1'b1 && mf_pin_o[0] === 1'b0)};
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [15:0] rx;
  logic oe_mid;

  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  monitor_control_pin_interface monitor_control_pin_interface_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .hw_reset_n_i(hw_reset_n_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .mf_pin_i(mf_pin_i), .mf_pin_o(mf_pin_o), .mf_pin_oe_o(mf_pin_oe_o),
    .out_of_range_i(out_of_range_i), .dac_clamp_o(dac_clamp_o), .dac_load_o(dac_load_o));

  serial_host_model serial_host_model_i (.sys_clk_i(sys_clk_i), .dout_o(dout_o),
    .dout_oe_o(dout_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      wrap_up();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask : wb

  task automatic cyc_n(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc_n

  task automatic pins(input logic [3:1] p);
    @(posedge sys_clk_i);
    pins_r <= p;
    cyc_n(5);
  endtask : pins

  task automatic range(input logic v);
    @(posedge sys_clk_i);
    out_of_range_i <= v;
    cyc_n(3);
  endtask : range

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wb(0, OFS_CTRL, 0);
    chk(rd, 0);
    wb(0, OFS_CLAMP, 0);
    chk(rd, 0);
    wb(0, 8'h20, 0);
    chk(rd, 0);
    chk(dout_oe_o, 0);
    chk(mf_pin_oe_o[0], 0);
    chk(dac_load_o, 0);
    wb(0, OFS_IRQ_STAT, 0);
    chk(rd, 0);
    $display("test reset done");
    wb(1, OFS_TX, 32'h0001a5c3);
    serial_host_model_i.xfer(16'h3c5a, rx, oe_mid);
    chk(rx, 16'ha5c3);
    chk(oe_mid, 1);
    cyc_n(8);
    chk(dout_oe_o, 0);
    wb(0, OFS_RX, 0);
    chk(rd, 32'h3c5a);
    wb(0, OFS_IRQ_STAT, 0);
    chk(rd[0], 1);
    chk(irq_o, 0);
    wb(1, OFS_IRQ_MASK, 1);
    cyc_n(2);
    chk(irq_o, 1);
    wb(1, OFS_IRQ_STAT, 1);
    cyc_n(2);
    chk(irq_o, 0);
    wb(1, OFS_TX, 32'h0000ffff);
    serial_host_model_i.xfer(16'h8001, rx, oe_mid);
    chk(oe_mid, 0);
    cyc_n(8);
    wb(0, OFS_RX, 0);
    chk(rd, 32'h8001);
    $display("test serial done");
    range(1);
    chk(mf_pin_oe_o[0], 1);
    chk(mf_pin_o[0], 0);
    wb(1, OFS_CTRL, 32'h10);
    cyc_n(3);
    chk(mf_pin_oe_o[0], 0);
    range(0);
    chk(mf_pin_oe_o[0], 1);
    range(1);
    wb(1, OFS_CTRL, 32'h01);
    wb(1, OFS_GPIO_OUT, 32'h11);
    cyc_n(3);
    chk(mf_pin_oe_o[0], 0);
    chk(mf_pin_o[0], 0);
    wb(1, OFS_GPIO_OUT, 32'h10);
    cyc_n(5);
    chk(mf_pin_oe_o[0], 1);
    wb(0, OFS_GPIO_IN, 0);
    chk(rd[0], 0);
    range(0);
    $display("test alert done");
    wb(1, OFS_CTRL, 0);
    wb(1, OFS_CLAMP, 32'h0f81);
    pins(3'b110);
    chk(dac_clamp_o, 8'h81);
    pins(3'b101);
    chk(dac_clamp_o, 8'h0f);
    pins(3'b100);
    chk(dac_clamp_o, 8'h8f);
    pins(3'b111);
    chk(dac_clamp_o, 8'h00);
    wb(1, OFS_CTRL, 32'h20);
    cyc_n(3);
    chk(dac_clamp_o, 8'h81);
    wb(0, OFS_GPIO_IN, 0);
    chk(rd[3:1], 3'b111);
    wb(1, OFS_CTRL, 32'h22);
    cyc_n(3);
    chk(dac_clamp_o, 8'h00);
    wb_sel_i <= 4'h2;
    wb(1, OFS_CLAMP, 32'h0000ffff);
    wb_sel_i <= 4'hf;
    wb(0, OFS_CLAMP, 0);
    chk(rd, 32'hff81);
    $display("test powerdown done");
    wb(1, OFS_CTRL, 0);
    wb(1, OFS_IRQ_STAT, 32'h7);
    wb(0, OFS_IRQ_STAT, 0);
    chk(rd, 0);
    pins(3'b011);
    chk(dac_load_o, 1);
    wb(0, OFS_IRQ_STAT, 0);
    chk(rd[2], 1);
    pins(3'b111);
    chk(dac_load_o, 0);
    wb(1, OFS_CTRL, 32'h80);
    cyc_n(3);
    chk(dac_load_o, 1);
    wb(1, OFS_CTRL, 32'h88);
    cyc_n(3);
    chk(dac_load_o, 0);
    wb(1, OFS_GPIO_OUT, 32'h88);
    cyc_n(2);
    chk(mf_pin_oe_o, 4'h8);
    chk(mf_pin_o, 4'h8);
    $display("test load done");
    wb(1, OFS_CTRL, 32'h5a);
    wb(0, OFS_CTRL, 0);
    chk(rd, 32'h5a);
    @(posedge sys_clk_i);
    hw_reset_n_i <= 1'b0;
    cyc_n(4);
    hw_reset_n_i <= 1'b1;
    cyc_n(5);
    wb(0, OFS_CTRL, 0);
    chk(rd, 0);
    wb(0, OFS_IRQ_MASK, 0);
    chk(rd, 0);
    chk(mf_pin_oe_o, 4'h0);
    $display("test hardware reset done");
    wrap_up();
  end
endmodule : tb_monitor_control_pin_interface
